// ### adcgc_host.sv
// adcgc_host: serial host model issuing byte accesses to the config bank
// assumes: one core clock; requests change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module adcgc_host
    import adcgc_pkg::*;
(
    // clock
    input  wire logic       core_clk_i,
    // register port
    output var  logic       reg_wr_o,
    output var  logic       reg_rd_o,
    output var  logic [7:0] reg_addr_o,
    output var  logic [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i
);
    // =========================================================
    // byte accesses, held across one rising edge
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(negedge core_clk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_rd_o   = 1'b1;
        reg_addr_o = a;
        @(negedge core_clk_i);
        reg_rd_o   = 1'b0;
        d          = reg_rdata_i;
    endtask
    // =========================================================
    // procedures
    task automatic slip();
        wr(ADDR_SLIP, 8'h00);
        wr(ADDR_SLIP, 8'h01);
    endtask
    // caller picks slow only for 40 to 100 msps clocks
    task automatic set_sec(input logic [7:0] want);
        logic [7:0] a;
        logic [7:0] b;
        rd(ADDR_FMT_SEC, a);
        rd(ADDR_LOOP_STATE, b);
        wr(ADDR_FMT_SEC, a ^ b ^ want);
    endtask
endmodule // adcgc_host
`default_nettype wire

// ### adcgc_pkg.sv
// adcgc_pkg: offsets, reset values and codes of the converter global config bank
// assumes: an 8-bit register port fed by the serial config front end
package adcgc_pkg;
    // =========================================================
    // register offsets
    localparam logic [7:0] ADDR_PORT_CFG   = 8'h00;
    localparam logic [7:0] ADDR_TRIM       = 8'h70;
    localparam logic [7:0] ADDR_SLIP       = 8'h71;
    localparam logic [7:0] ADDR_DIV_SEL    = 8'h72;
    localparam logic [7:0] ADDR_FMT_PRI    = 8'h73;
    localparam logic [7:0] ADDR_FMT_SEC    = 8'h74;
    localparam logic [7:0] ADDR_LOOP_STATE = 8'h75;
    localparam logic [7:0] ADDR_PAT_CTL    = 8'hc0;
    localparam logic [7:0] ADDR_W1_LO      = 8'hc2;
    localparam logic [7:0] ADDR_W1_HI      = 8'hc3;
    localparam logic [7:0] ADDR_W2_LO      = 8'hc4;
    localparam logic [7:0] ADDR_W2_HI      = 8'hc5;
    // =========================================================
    // field positions
    localparam int SOFT_RST_BIT  = 5;
    localparam int LOOP_SLOW_BIT = 6;
    localparam int SLIP_BIT      = 0;
    // =========================================================
    // reset value and trim midscale
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] TRIM_MID = 8'h80;
    // =========================================================
    // three-bit selection codes (shared by divider, mode and coding)
    localparam logic [2:0] SEL_PIN = 3'h0;
    localparam logic [2:0] SEL_A   = 3'h1;
    localparam logic [2:0] SEL_B   = 3'h2;
    localparam logic [2:0] SEL_C   = 3'h4;
    // =========================================================
    // test pattern codes and words, divide-by-four slip step
    localparam logic [1:0] TM_STATIC = 2'h0;
    localparam logic [1:0] TM_ALT    = 2'h1;
    localparam logic [3:0] PAT_OFF   = 4'h0;
    localparam logic [3:0] PAT_MID   = 4'h1;
    localparam logic [3:0] PAT_ONES  = 4'h2;
    localparam logic [3:0] PAT_ZEROS = 4'h3;
    localparam logic [3:0] PAT_CHECK = 4'h4;
    localparam logic [3:0] PAT_ONEZ  = 4'h7;
    localparam logic [3:0] PAT_USER  = 4'h8;
    localparam logic [15:0] W_MID    = 16'h8000;
    localparam logic [15:0] W_ONES   = 16'hffff;
    localparam logic [15:0] W_ZEROS  = 16'h0000;
    localparam logic [15:0] W_CHK_A  = 16'haaaa;
    localparam logic [15:0] W_CHK_B  = 16'h5555;
    localparam logic [1:0]  DIV4_STEP = 2'h2;
endpackage

// ### adcgc_top.sv
// adcgc_top: global config and test-pattern register bank of a dual 10-bit converter
// assumes: serial front end presents byte reads/writes on core_clk; pins are asynchronous
// How it works
// - trim register is 8 bits, 0x80 mid, driven to skew trim output.
// - trim register holds zero after reset.
// - in divide-by-four, a slip advances the divided edge one input cycle.
// - divider field decodes 000 pin, 001 /1, 010 /2, 100 /4.
// - divider code zero takes divisor from tri-level pin.
// - divider select and primary format survive soft reset.
// - mode field bits 7:5 decode pin, low drive, high drive, CMOS.
// - coding field bits 2:0 decode pin, two's complement, Gray, binary.
// - status bit 6 selects loop range, fast at reset.
// - test drives static word or two words alternating each cycle.
// - test enable crosses a two-stage delay before outputs follow.
// - control bits 7:6 choose static or alternating; other values reserved.
// - nibble codes off, midscale, all ones, all zeros; 5,6 reserved.
// - code 4 checkerboard, 7 ones/zeros, 8 user words alternate.
// - 0xc2/0xc3 hold low/high bytes of first user word.
// - 0xc4/0xc5 hold low/high bytes of second user word.
// - soft reset bit restores defaults except protected registers.
`timescale 1ns/1ps
`default_nettype none
module adcgc_top
    import adcgc_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // register port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output var  logic [7:0] reg_rdata_o,
    output var  logic       reg_rvalid_o,
    // tri-level pins (00 low, 01 mid, 1x high)
    input  wire logic [1:0] divider_pin_i,
    input  wire logic [1:0] output_mode_pin_i,
    input  wire logic [1:0] coding_pin_i,
    // configuration outputs
    output var  logic [7:0] skew_trim_o,
    output var  logic [2:0] divisor_code_o,
    output var  logic       div_en_o,
    output var  logic [2:0] output_mode_o,
    output var  logic [2:0] coding_o,
    output var  logic       loop_slow_o,
    // test pattern outputs
    output var  logic       test_active_o,
    output var  logic [9:0] test_data_o
);
    import adcgc_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        logic [7:0] port_cfg;
        logic [7:0] trim;
        logic [7:0] slip;
        logic [7:0] div_sel;
        logic [7:0] fmt_pri;
        logic [7:0] fmt_sec;
        logic [7:0] loop_st;
        logic [7:0] pat_ctl;
        logic [7:0] w1_lo;
        logic [7:0] w1_hi;
        logic [7:0] w2_lo;
        logic [7:0] w2_hi;
        logic [7:0] rdata;
        logic       rvalid;
        logic       slip_arm;
        logic       slip_req;
        logic [1:0] cnt;
        logic       div_en;
        logic [2:0] divisor;
        logic [2:0] omode;
        logic [2:0] coding;
        logic [1:0] dp1, dp2, mp1, mp2, cp1, cp2;
        logic       ten1, ten2;
        logic       phase;
        logic       tact;
        logic [9:0] tdata;
    } adcgc_state_s;

    adcgc_state_s st_r, st_nxt;

    // tri-level pin to one-hot selection code
    function automatic logic [2:0] pin_code(input logic [1:0] p);
        pin_code = (p == 2'h0) ? SEL_A : ((p == 2'h1) ? SEL_B : SEL_C);
    endfunction

    // register code overrides pin; invalid codes fall back to the pin
    function automatic logic [2:0] pick(input logic [2:0] r, input logic [1:0] p);
        pick = (r == SEL_A || r == SEL_B || r == SEL_C) ? r : pin_code(p);
    endfunction

    logic       soft_rst;
    logic       wr_slip;
    logic [7:0] sec_dec;
    logic [15:0] word1;
    logic [15:0] word2;
    logic        alt;
    logic        pat_on;

    // =========================================================
    // next state
    always_comb begin
        st_nxt   = st_r;
        soft_rst = reg_wr_i && reg_addr_i == ADDR_PORT_CFG && reg_wdata_i[SOFT_RST_BIT];
        wr_slip  = reg_wr_i && reg_addr_i == ADDR_SLIP;
        sec_dec  = reg_wdata_i ^ st_r.fmt_sec ^ st_r.loop_st;
        word1    = W_ZEROS;
        word2    = W_ZEROS;
        alt      = 1'b0;
        pat_on   = 1'b1;
        // pin synchronisers
        st_nxt.dp1 = divider_pin_i;
        st_nxt.dp2 = st_r.dp1;
        st_nxt.mp1 = output_mode_pin_i;
        st_nxt.mp2 = st_r.mp1;
        st_nxt.cp1 = coding_pin_i;
        st_nxt.cp2 = st_r.cp1;
        // register writes
        st_nxt.slip_req = 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_PORT_CFG:   st_nxt.port_cfg = reg_wdata_i & ~(8'h01 << SOFT_RST_BIT);
                ADDR_TRIM:       st_nxt.trim = reg_wdata_i;
                ADDR_SLIP:       st_nxt.slip = reg_wdata_i;
                ADDR_DIV_SEL:    st_nxt.div_sel = reg_wdata_i;
                ADDR_FMT_PRI:    st_nxt.fmt_pri = reg_wdata_i;
                ADDR_FMT_SEC: begin
                    st_nxt.fmt_sec = sec_dec;
                    st_nxt.loop_st[LOOP_SLOW_BIT] = sec_dec[LOOP_SLOW_BIT];
                end
                ADDR_PAT_CTL:    st_nxt.pat_ctl = reg_wdata_i;
                ADDR_W1_LO:      st_nxt.w1_lo = reg_wdata_i;
                ADDR_W1_HI:      st_nxt.w1_hi = reg_wdata_i;
                ADDR_W2_LO:      st_nxt.w2_lo = reg_wdata_i;
                ADDR_W2_HI:      st_nxt.w2_hi = reg_wdata_i;
                default:         st_nxt.rvalid = st_r.rvalid;
            endcase
        end
        // slip: zero arms, one fires
        if (wr_slip && !reg_wdata_i[SLIP_BIT]) begin
            st_nxt.slip_arm = 1'b1;
        end
        if (wr_slip && reg_wdata_i[SLIP_BIT] && st_r.slip_arm) begin
            st_nxt.slip_arm = 1'b0;
            st_nxt.slip_req = 1'b1;
        end
        // soft reset spares divider select and primary format
        if (soft_rst) begin
            st_nxt.port_cfg = RST_BYTE;
            st_nxt.trim     = RST_BYTE;
            st_nxt.slip     = RST_BYTE;
            st_nxt.fmt_sec  = RST_BYTE;
            st_nxt.loop_st  = RST_BYTE;
            st_nxt.pat_ctl  = RST_BYTE;
            st_nxt.w1_lo    = RST_BYTE;
            st_nxt.w1_hi    = RST_BYTE;
            st_nxt.w2_lo    = RST_BYTE;
            st_nxt.w2_hi    = RST_BYTE;
            st_nxt.slip_arm = 1'b0;
            st_nxt.slip_req = 1'b0;
        end
        // read path, unmapped reads as zero
        st_nxt.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_PORT_CFG:   st_nxt.rdata = st_r.port_cfg;
                ADDR_TRIM:       st_nxt.rdata = st_r.trim;
                ADDR_SLIP:       st_nxt.rdata = st_r.slip;
                ADDR_DIV_SEL:    st_nxt.rdata = st_r.div_sel;
                ADDR_FMT_PRI:    st_nxt.rdata = st_r.fmt_pri;
                ADDR_FMT_SEC:    st_nxt.rdata = st_r.fmt_sec;
                ADDR_LOOP_STATE: st_nxt.rdata = st_r.loop_st;
                ADDR_PAT_CTL:    st_nxt.rdata = st_r.pat_ctl;
                ADDR_W1_LO:      st_nxt.rdata = st_r.w1_lo;
                ADDR_W1_HI:      st_nxt.rdata = st_r.w1_hi;
                ADDR_W2_LO:      st_nxt.rdata = st_r.w2_lo;
                ADDR_W2_HI:      st_nxt.rdata = st_r.w2_hi;
                default:         st_nxt.rdata = RST_BYTE;
            endcase
        end
        // =====================================================
        // effective selections
        st_nxt.divisor = pick(st_r.div_sel[2:0], st_r.dp2);
        st_nxt.omode   = pick(st_r.fmt_pri[7:5], st_r.mp2);
        st_nxt.coding  = pick(st_r.fmt_pri[2:0], st_r.cp2);
        // =====================================================
        // divider; a slip outside divide-by-four is dropped
        case (st_r.divisor)
            SEL_C: begin
                if (st_r.slip_req) begin
                    st_nxt.cnt = st_r.cnt + DIV4_STEP;
                end else begin
                    st_nxt.cnt = st_r.cnt + 2'h1;
                end
            end
            SEL_B:   st_nxt.cnt = {1'b0, ~st_r.cnt[0]};
            default: st_nxt.cnt = 2'h0;
        endcase
        st_nxt.div_en = (st_nxt.cnt == 2'h0);
        // =====================================================
        // test pattern; enable passes two stages as if crossing
        case (st_r.pat_ctl[3:0])
            PAT_MID:   word1 = W_MID;
            PAT_ONES:  word1 = W_ONES;
            PAT_ZEROS: word1 = W_ZEROS;
            PAT_CHECK: begin
                word1 = W_CHK_A;
                word2 = W_CHK_B;
            end
            PAT_ONEZ: begin
                word1 = W_ONES;
                word2 = W_ZEROS;
            end
            PAT_USER: begin
                word1 = {st_r.w1_hi, st_r.w1_lo};
                word2 = {st_r.w2_hi, st_r.w2_lo};
            end
            default:   pat_on = 1'b0;
        endcase
        // reserved modes 2 and 3 leave the pattern off
        if (st_r.pat_ctl[7:6] == TM_ALT) begin
            alt = (st_r.pat_ctl[3:0] == PAT_CHECK) || (st_r.pat_ctl[3:0] == PAT_ONEZ)
                || (st_r.pat_ctl[3:0] == PAT_USER);
        end else if (st_r.pat_ctl[7:6] != TM_STATIC) begin
            pat_on = 1'b0;
        end
        st_nxt.ten1  = pat_on;
        st_nxt.ten2  = st_r.ten1;
        st_nxt.tact  = st_r.ten2;
        st_nxt.phase = st_r.ten2 && alt && !st_r.phase;
        if (!st_r.ten2) begin
            st_nxt.tdata = 10'h000;
        end else if (alt && st_r.phase) begin
            st_nxt.tdata = word2[15:6];
        end else begin
            st_nxt.tdata = word1[15:6];
        end
    end

    // =========================================================
    // register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // outputs
    assign reg_rdata_o    = st_r.rdata;
    assign reg_rvalid_o   = st_r.rvalid;
    assign skew_trim_o    = st_r.trim;
    assign divisor_code_o = st_r.divisor;
    assign div_en_o       = st_r.div_en;
    assign output_mode_o  = st_r.omode;
    assign coding_o       = st_r.coding;
    assign loop_slow_o    = st_r.loop_st[LOOP_SLOW_BIT];
    assign test_active_o  = st_r.tact;
    assign test_data_o    = st_r.tdata;

    // =========================================================
    // checks
    property p_trim_wr;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == ADDR_TRIM |=> skew_trim_o == $past(reg_wdata_i);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim not stored");

    property p_slip_div4;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        st_r.slip_req && st_r.divisor == SEL_C |=> st_r.cnt == $past(st_r.cnt) + DIV4_STEP;
    endproperty
    a_slip_div4: assert property (p_slip_div4) else $error("slip did not advance");

    property p_div4_period;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        div_en_o && st_r.divisor == SEL_C && !st_r.slip_req
            ##1 (st_r.divisor == SEL_C && !st_r.slip_req) [*2] |=> div_en_o == 1'b0;
    endproperty
    a_div4_period: assert property (p_div4_period) else $error("div4 edge early");

    property p_pin_ctl;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        st_r.div_sel[2:0] == SEL_PIN && $stable(st_r.dp2) |=> divisor_code_o
            == pin_code($past(st_r.dp2));
    endproperty
    a_pin_ctl: assert property (p_pin_ctl) else $error("pin divisor ignored");

    property p_soft_keep;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        soft_rst |=> st_r.div_sel == $past(st_r.div_sel) && st_r.fmt_pri == $past(st_r.fmt_pri)
            && st_r.trim == RST_BYTE;
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset wrong");

    property p_sec_xor;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == ADDR_FMT_SEC && !soft_rst |=> st_r.fmt_sec
            == ($past(reg_wdata_i) ^ $past(st_r.fmt_sec) ^ $past(st_r.loop_st));
    endproperty
    a_sec_xor: assert property (p_sec_xor) else $error("xor write wrong");

    property p_test_delay;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        st_r.ten1 && !st_r.ten2 |-> !test_active_o ##1 !test_active_o ##1 test_active_o
            || !st_r.ten1;
    endproperty
    a_test_delay: assert property (p_test_delay) else $error("test enable delay");

    property p_alt_words;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        test_active_o && st_r.pat_ctl == {TM_ALT, 2'h0, PAT_CHECK} ##1
            $stable(st_r.pat_ctl) |-> test_data_o != $past(test_data_o);
    endproperty
    a_alt_words: assert property (p_alt_words) else $error("no alternation");

    property p_mid_word;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        st_r.ten2 && st_r.pat_ctl == {TM_STATIC, 2'h0, PAT_MID} |=> test_data_o == W_MID[15:6];
    endproperty
    a_mid_word: assert property (p_mid_word) else $error("midscale word wrong");
endmodule // adcgc_top
`default_nettype wire

// ### test_adcgc_top.sv
// test_adcgc_top: self-checking bench for the global config bank
// assumes: host model drives the register port, bench drives pins
`timescale 1ns/1ps
`default_nettype none
module test_adcgc_top;
    import adcgc_pkg::*;
    logic       core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, div_en_o;
    logic       loop_slow_o, test_active_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, skew_trim_o;
    logic [1:0] pin_r;
    logic [2:0] divisor_code_o, output_mode_o, coding_o;
    logic [9:0] test_data_o;
    logic [7:0] rq[$];
    logic [15:0] w1, w2;
    int         failures, samples_checked, cyc, seed, t0, t1, n;
    adcgc_host host (.core_clk_i(core_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o));
    adcgc_top uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .divider_pin_i(pin_r),
        .output_mode_pin_i(pin_r), .coding_pin_i(pin_r), .skew_trim_o(skew_trim_o),
        .divisor_code_o(divisor_code_o), .div_en_o(div_en_o), .output_mode_o(output_mode_o),
        .coding_o(coding_o), .loop_slow_o(loop_slow_o), .test_active_o(test_active_o),
        .test_data_o(test_data_o));
    // =========================================================
    // clock, timeout, read monitor
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    always @(negedge core_clk_i) begin
        if (reg_rvalid_o === 1'b1 && rq.size() > 0) begin
            check("read_data", reg_rdata_o, rq.pop_front());
        end
    end
    // =========================================================
    // helpers
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rq.push_back(e);
        host.rd(a, d);
    endtask
    // slip is invisible in the period alone, so compare edge phase
    task automatic en_time(output int t);
        @(negedge core_clk_i);
        for (int i = 0; i < 8 && div_en_o !== 1'b1; i++) @(negedge core_clk_i);
        check("div_en", div_en_o, 1'b1);
        t = cyc;
    endtask
    task automatic end_of_test();
        if (rq.size() != 0) failures++;
        if (failures == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // =========================================================
    // main sequence
    initial begin
        logic [7:0]  tv[4], ctl[11];
        logic [15:0] wa[11], wb[11];
        seed = 21;
        pin_r = 2'h0;
        reset_n_i = 1'b0;
        repeat (20) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        @(negedge core_clk_i);
        check("trim_out", skew_trim_o, 8'h00);
        check("loop_slow", loop_slow_o, 1'b0);
        rchk(ADDR_TRIM, RST_BYTE);
        rchk(8'h33, 8'h00);
        tv = '{8'h00, TRIM_MID, 8'hff, 8'h00};
        tv[3] = 8'($random(seed));
        foreach (tv[i]) begin
            host.wr(ADDR_TRIM, tv[i]);
            rchk(ADDR_TRIM, tv[i]);
            check("trim_out", skew_trim_o, tv[i]);
        end
        for (int p = 0; p < 3; p++) begin
            pin_r = p[1:0];
            repeat (5) @(negedge core_clk_i);
            check("div_pin", divisor_code_o, 3'h1 << p);
            check("mode_pin", output_mode_o, 3'h1 << p);
            check("code_pin", coding_o, 3'h1 << p);
        end
        pin_r = 2'h1;
        for (int k = 0; k < 3; k++) begin
            host.wr(ADDR_DIV_SEL, 8'h01 << k);
            host.wr(ADDR_FMT_PRI, {3'h1 << k, 2'h0, 3'h1 << k});
            repeat (2) @(negedge core_clk_i);
            check("div_reg", divisor_code_o, 3'h1 << k);
            check("mode_reg", output_mode_o, 3'h1 << k);
            check("code_reg", coding_o, 3'h1 << k);
            en_time(t0);
            en_time(t1);
            check("div_period", 16'(t1 - t0), 16'h1 << k);
        end
        host.wr(ADDR_DIV_SEL, 8'h03);
        repeat (5) @(negedge core_clk_i);
        check("div_bad", divisor_code_o, SEL_B);
        host.wr(ADDR_DIV_SEL, 8'h04);
        host.wr(ADDR_TRIM, 8'h5a);
        host.wr(ADDR_W1_LO, 8'h33);
        host.wr(ADDR_PORT_CFG, 8'h20);
        rchk(ADDR_DIV_SEL, 8'h04);
        rchk(ADDR_FMT_PRI, 8'h84);
        rchk(ADDR_TRIM, 8'h00);
        rchk(ADDR_W1_LO, 8'h00);
        host.set_sec(8'h40);
        check("loop_slow", loop_slow_o, 1'b1);
        rchk(ADDR_LOOP_STATE, 8'h40);
        rchk(ADDR_FMT_SEC, 8'h40);
        host.wr(ADDR_LOOP_STATE, 8'hff);
        host.set_sec(8'h00);
        check("loop_slow", loop_slow_o, 1'b0);
        en_time(t0);
        host.slip();
        repeat (4) @(negedge core_clk_i);
        en_time(t1);
        check("slip_phase", 16'((t1 - t0) % 4), 16'h3);
        en_time(t0);
        host.wr(ADDR_SLIP, 8'h01);
        repeat (4) @(negedge core_clk_i);
        en_time(t1);
        check("lone_slip", 16'((t1 - t0) % 4), 16'h0);
        w1 = 16'($random(seed));
        w2 = 16'($random(seed));
        host.wr(ADDR_W1_LO, w1[7:0]);
        host.wr(ADDR_W1_HI, w1[15:8]);
        host.wr(ADDR_W2_LO, w2[7:0]);
        host.wr(ADDR_W2_HI, w2[15:8]);
        rchk(ADDR_W1_LO, w1[7:0]);
        rchk(ADDR_W1_HI, w1[15:8]);
        rchk(ADDR_W2_LO, w2[7:0]);
        rchk(ADDR_W2_HI, w2[15:8]);
        // alternate mode with a static code stays static; mode 10 is reserved
        ctl = '{8'h01, 8'h02, 8'h03, 8'h44, 8'h47, 8'h48, 8'h08, 8'h42, 8'h05, 8'h06,
            8'h81};
        wa = '{W_MID, W_ONES, W_ZEROS, W_CHK_A, W_ONES, w1, w1, W_ONES, 16'h0, 16'h0,
            16'h0};
        wb = '{W_MID, W_ONES, W_ZEROS, W_CHK_B, W_ZEROS, w2, w1, W_ONES, 16'h0, 16'h0,
            16'h0};
        foreach (ctl[i]) begin
            host.wr(ADDR_PAT_CTL, ctl[i]);
            for (n = 0; n < 8 && test_active_o !== 1'b1; n++) @(negedge core_clk_i);
            check("pat_active", test_active_o, i < 8);
            if (i < 8) begin
                check("pat_w1", test_data_o, wa[i][15:6]);
                @(negedge core_clk_i);
                check("pat_w2", test_data_o, wb[i][15:6]);
                @(negedge core_clk_i);
                check("pat_w1", test_data_o, wa[i][15:6]);
            end
            host.wr(ADDR_PAT_CTL, 8'h00);
            repeat (5) @(negedge core_clk_i);
            check("pat_off", {test_active_o, test_data_o}, 11'h0);
        end
        end_of_test();
    end
endmodule // test_adcgc_top
`default_nettype wire
